// ### rtl/isq_alu.sv
// eight-bit alu of the execute stage
`timescale 1ns/100ps
module isq_alu (
  // operation and operands
  input logic [3:0] op,
  input logic [7:0] a,
  input logic [7:0] b,
  input logic carry_in,
  // result and flags
  output logic [7:0] y,
  output logic carry_out,
  output logic zero
);

  logic [8:0] sum;

  // carry on subtraction means no borrow
  always_comb begin
    sum = 9'h000;
    y = a;
    carry_out = carry_in;
    unique case (isq_pkg::isq_alu_op_t'(op))
      isq_pkg::ISQ_ADD: sum = {1'b0, a} + {1'b0, b};
      isq_pkg::ISQ_ADC: sum = {1'b0, a} + {1'b0, b} + {8'h00, carry_in};
      isq_pkg::ISQ_SUB: sum = {1'b0, a} + {1'b0, ~b} + 9'h001;
      isq_pkg::ISQ_SBC: sum = {1'b0, a} + {1'b0, ~b} + {8'h00, carry_in};
      isq_pkg::ISQ_AND: y = a & b;
      isq_pkg::ISQ_OR: y = a | b;
      isq_pkg::ISQ_XOR: y = a ^ b;
      isq_pkg::ISQ_CPL: y = ~a;
      isq_pkg::ISQ_RR: y = {a[0], a[7:1]};
      isq_pkg::ISQ_RRC: begin
        y = {carry_in, a[7:1]};
        carry_out = a[0];
      end
      isq_pkg::ISQ_RL: y = {a[6:0], a[7]};
      isq_pkg::ISQ_RLC: begin
        y = {a[6:0], carry_in};
        carry_out = a[7];
      end
      isq_pkg::ISQ_INC: y = a + 8'h01;
      isq_pkg::ISQ_DEC: y = a - 8'h01;
      isq_pkg::ISQ_PASS: y = a;
      default: y = a;
    endcase
    // add and subtract classes (op 0 to 3) take result and carry from the adder
    if (op <= 4'h3) begin
      y = sum[7:0];
      carry_out = sum[8];
    end
    zero = (y == 8'h00);
  end

endmodule

// ### rtl/isq_pkg.sv
// shared constants and types of the instruction sequencer
package isq_pkg;

  // widths and depths
  localparam int PC_W = 13;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;
  localparam int REG_ADDR_W = 4;
  localparam int STK_PTR_W = 3;
  localparam logic [3:0] STK_DEPTH = 4'h8;

  // register offsets on the plain register port
  localparam logic [3:0] REG_PCL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;

  // status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_ZERO = 1;

  // values after reset
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [7:0] PCL_RESET = 8'h00;
  localparam logic [2:0] STK_PTR_RESET = 3'h0;
  localparam logic [3:0] STK_DEPTH_RESET = 4'h0;

  // one phase per sys_clk cycle, four phases per instruction cycle
  typedef enum logic [3:0] {
    ISQ_T1 = 4'b0001,
    ISQ_T2 = 4'b0010,
    ISQ_T3 = 4'b0100,
    ISQ_T4 = 4'b1000
  } isq_phase_t;

  // alu operation classes
  typedef enum logic [3:0] {
    ISQ_ADD = 4'h0,
    ISQ_ADC = 4'h1,
    ISQ_SUB = 4'h2,
    ISQ_SBC = 4'h3,
    ISQ_AND = 4'h4,
    ISQ_OR = 4'h5,
    ISQ_XOR = 4'h6,
    ISQ_CPL = 4'h7,
    ISQ_RR = 4'h8,
    ISQ_RRC = 4'h9,
    ISQ_RL = 4'ha,
    ISQ_RLC = 4'hb,
    ISQ_INC = 4'hc,
    ISQ_DEC = 4'hd,
    ISQ_PASS = 4'he
  } isq_alu_op_t;

endpackage

// ### rtl/isq_sequencer.sv
// instruction sequencer: phase timing, program counter, return stack
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module isq_sequencer (
  // clock and reset
  input logic sys_clk,
  input logic rst,
  // register port
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  // program memory
  output logic [12:0] fetch_addr,
  output logic fetch_req,
  input logic [15:0] fetch_instr,
  // phase clocks and instruction to the execute datapath
  output logic [3:0] instruction_phase_clocks,
  output logic [15:0] exec_instr,
  output logic exec_valid,
  output logic exec_second,
  // flow control from the execute datapath, sampled in the last phase
  input logic ctl_unconditional_jump,
  input logic ctl_call,
  input logic ctl_subroutine_return,
  input logic ctl_interrupt_return,
  input logic ctl_skip,
  input logic ctl_ext,
  input logic [12:0] ctl_target,
  // alu request from the execute datapath, sampled in the third phase
  input logic alu_en,
  input logic [3:0] alu_op,
  input logic [7:0] alu_a,
  input logic [7:0] alu_b,
  input logic [7:0] alu_dest,
  // alu result to the register file
  output logic [7:0] alu_result,
  output logic alu_wr,
  output logic [7:0] alu_wr_addr,
  output logic status_carry,
  output logic status_zero,
  // interrupt controller
  input logic int_req,
  input logic [12:0] int_vector,
  output logic int_ack
);

  isq_pkg::isq_phase_t phase;
  isq_pkg::isq_phase_t next_phase;
  logic [12:0] pc;
  logic [12:0] next_pc;
  logic [15:0] prefetch;
  logic fetch_got;
  logic act;
  logic do_ret;
  logic do_jump;
  logic do_call;
  logic do_pcl;
  logic do_stall;
  logic do_skip;
  logic do_int;
  logic flush;
  logic pcl_wr;
  logic pcl_pend;
  logic [7:0] pcl_val;
  logic pcl_hit;
  logic [7:0] pcl_val_now;
  logic [12:0] stk_mem [0:7];
  logic [2:0] stk_wp;
  logic [2:0] top_idx;
  logic [3:0] stk_depth;
  logic stk_full;
  logic [12:0] pop_val;
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_z;

  assign fetch_addr = pc;

  // phase ring; one phase per sys_clk edge
  always_comb begin
    unique case (phase)
      isq_pkg::ISQ_T1: next_phase = isq_pkg::ISQ_T2;
      isq_pkg::ISQ_T2: next_phase = isq_pkg::ISQ_T3;
      isq_pkg::ISQ_T3: next_phase = isq_pkg::ISQ_T4;
      isq_pkg::ISQ_T4: next_phase = isq_pkg::ISQ_T1;
      default: next_phase = isq_pkg::ISQ_T1;
    endcase
  end

  // phase register and its copy on the output pins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      phase <= isq_pkg::ISQ_T1;
      instruction_phase_clocks <= isq_pkg::ISQ_T1;
    end else begin
      phase <= next_phase;
      instruction_phase_clocks <= next_phase;
    end
  end

  // stack bookkeeping
  assign top_idx = stk_wp - 3'h1;
  assign pop_val = stk_mem[top_idx];
  assign stk_full = (stk_depth == isq_pkg::STK_DEPTH);

  // low byte write from software; consumed at the end of an instruction
  assign pcl_wr = reg_wr && (reg_addr == isq_pkg::REG_PCL);
  assign pcl_hit = pcl_pend || pcl_wr;
  assign pcl_val_now = pcl_wr ? reg_wdata : pcl_val;

  // flow decision at the end of the last phase; first hit wins
  always_comb begin
    act = (phase == isq_pkg::ISQ_T4) && exec_valid;
    do_ret = act && (ctl_subroutine_return || ctl_interrupt_return);
    do_jump = act && !do_ret && (ctl_unconditional_jump || ctl_call);
    do_call = do_jump && ctl_call;
    do_pcl = act && !do_ret && !do_jump && pcl_hit;
    do_stall = act && ctl_ext && !exec_second && !do_ret && !do_jump &&
               !do_pcl;
    do_skip = act && ctl_skip && !do_ret && !do_jump && !do_pcl &&
              !do_stall;
    // a full stack keeps the request pending instead of losing it
    do_int = act && int_req && !stk_full && !do_ret && !do_jump &&
             !do_pcl && !do_stall && !do_skip;
    flush = do_ret || do_jump || do_pcl || do_skip || do_int;
    next_pc = pc + 13'h0001;
    if (do_ret) begin
      next_pc = pop_val;
    end else if (do_jump) begin
      next_pc = ctl_target;
    end else if (do_pcl) begin
      next_pc = {pc[12:8], pcl_val_now};
    end else if (do_stall) begin
      next_pc = pc;
    end else if (do_int) begin
      next_pc = int_vector;
    end
  end

  // program counter: next address steps or loads at the start of T1
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pc <= isq_pkg::PC_RESET;
    end else if (phase == isq_pkg::ISQ_T4) begin
      pc <= next_pc;
    end
  end

  // fetch strobe lives in T1; no fetch while an extended op holds
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fetch_req <= 1'b1;
      fetch_got <= 1'b0;
    end else begin
      fetch_req <= (phase == isq_pkg::ISQ_T4) && !do_stall;
      fetch_got <= fetch_req;
    end
  end

  // program memory answers one cycle after the strobe
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      prefetch <= 16'h0000;
    end else if (phase == isq_pkg::ISQ_T2 && fetch_got) begin
      prefetch <= fetch_instr;
    end
  end

  // hand the prefetched word to execute; flushed slots become dummies
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      exec_instr <= 16'h0000;
      exec_valid <= 1'b0;
      exec_second <= 1'b0;
    end else if (phase == isq_pkg::ISQ_T4) begin
      if (!do_stall) begin
        exec_instr <= prefetch;
      end
      exec_valid <= !flush;
      exec_second <= do_stall;
    end
  end

  // pending low byte write; a write in the decision cycle is consumed there and not kept pending
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pcl_pend <= 1'b0;
      pcl_val <= isq_pkg::PCL_RESET;
    end else begin
      if (pcl_wr) begin
        pcl_val <= reg_wdata;
      end
      if (pcl_wr && !act) begin
        pcl_pend <= 1'b1;
      end else if (act) begin
        pcl_pend <= 1'b0;
      end
    end
  end

  // stack pointer and depth; memory wraps so the oldest entry drops
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stk_wp <= isq_pkg::STK_PTR_RESET;
      stk_depth <= isq_pkg::STK_DEPTH_RESET;
    end else if (do_call || do_int) begin
      stk_wp <= stk_wp + 3'h1;
      if (!stk_full) begin
        stk_depth <= stk_depth + 4'h1;
      end
    end else if (do_ret) begin
      stk_wp <= top_idx;
      if (stk_depth != 4'h0) begin
        stk_depth <= stk_depth - 4'h1;
      end
    end
  end

  // stack storage has no reset; never reached by the register port
  always_ff @(posedge sys_clk) begin
    if (do_call || do_int) begin
      stk_mem[stk_wp] <= pc;
    end
  end

  // acknowledge pulse in T1 of the vectored cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_ack <= 1'b0;
    end else begin
      int_ack <= do_int;
    end
  end

  isq_alu u_alu (
    .op(alu_op),
    .a(alu_a),
    .b(alu_b),
    .carry_in(status_carry),
    .y(alu_y),
    .carry_out(alu_c),
    .zero(alu_z)
  );

  // alu result captured in T3, written back during T4
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      alu_result <= 8'h00;
      alu_wr <= 1'b0;
      alu_wr_addr <= 8'h00;
      status_carry <= 1'b0;
      status_zero <= 1'b0;
    end else begin
      alu_wr <= 1'b0;
      if (phase == isq_pkg::ISQ_T3 && exec_valid && alu_en) begin
        alu_result <= alu_y;
        alu_wr <= 1'b1;
        alu_wr_addr <= alu_dest;
        status_carry <= alu_c;
        status_zero <= alu_z;
      end
    end
  end

  // read data stand one cycle only; unmapped offsets read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        if (reg_addr == isq_pkg::REG_PCL) begin
          reg_rdata <= pc[7:0];
        end else if (reg_addr == isq_pkg::REG_STATUS) begin
          reg_rdata <= {6'h00, status_zero, status_carry};
        end
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_phase_walk;
    phase == isq_pkg::ISQ_T1 ##1 phase == isq_pkg::ISQ_T2 ##1
    phase == isq_pkg::ISQ_T3 ##1 phase == isq_pkg::ISQ_T4;
  endsequence

  sequence s_dummy_slot;
    (!exec_valid)[*4] ##1 exec_valid;
  endsequence

  property p_phase_cycle;
    // the edge that releases reset still samples reset high
    !rst && phase == isq_pkg::ISQ_T1 |->
      s_phase_walk ##1 phase == isq_pkg::ISQ_T1;
  endproperty
  a_phase_cycle: assert property (p_phase_cycle)
    else $error("phase order broken");

  property p_fetch_in_t1;
    // reset leaves the strobe up so address zero is fetched at release
    fetch_req |-> instruction_phase_clocks == 4'b0001 &&
                  ($past(phase) == isq_pkg::ISQ_T4 || $past(rst));
  endproperty
  a_fetch_in_t1: assert property (p_fetch_in_t1)
    else $error("fetch outside first phase");

  property p_alu_late;
    alu_wr |-> phase == isq_pkg::ISQ_T4 && $past(alu_en) &&
               status_zero == (alu_result == 8'h00);
  endproperty
  a_alu_late: assert property (p_alu_late)
    else $error("alu write out of phase or wrong zero flag");

  property p_pc_step;
    phase == isq_pkg::ISQ_T4 && !flush && !do_stall |=>
      pc == $past(pc) + 13'h0001;
  endproperty
  a_pc_step: assert property (p_pc_step)
    else $error("pc did not advance by one");

  property p_jump_dummy;
    do_jump |=> pc == $past(ctl_target) ##0 s_dummy_slot;
  endproperty
  a_jump_dummy: assert property (p_jump_dummy)
    else $error("branch without target load or dummy cycle");

  property p_skip_dummy;
    do_skip |=> s_dummy_slot;
  endproperty
  a_skip_dummy: assert property (p_skip_dummy)
    else $error("skip did not discard prefetched word");

  property p_ext_hold;
    do_stall |=> (exec_second && !fetch_req) ##1 exec_second[*3]
                 ##1 !exec_second;
  endproperty
  a_ext_hold: assert property (p_ext_hold)
    else $error("extended instruction not held two cycles");

  property p_pcl_page;
    do_pcl |=> pc[12:8] == $past(pc[12:8]) &&
               pc[7:0] == $past(pcl_val_now) && !exec_valid;
  endproperty
  a_pcl_page: assert property (p_pcl_page)
    else $error("low byte write left the page");

  property p_push;
    do_call |=> stk_mem[top_idx] == $past(pc) && pc == $past(ctl_target);
  endproperty
  a_push: assert property (p_push)
    else $error("call did not push pc");

  property p_pop;
    do_ret && stk_depth != 4'h0 |=>
      pc == $past(pop_val) && stk_depth == $past(stk_depth) - 4'h1;
  endproperty
  a_pop: assert property (p_pop)
    else $error("return did not restore pc");

  property p_int_held;
    // a return in the same decision frees a level, so fullness may end
    act && int_req && stk_full && !do_ret |=> !int_ack && stk_full;
  endproperty
  a_int_held: assert property (p_int_held)
    else $error("interrupt taken on full stack");

  property p_overflow;
    do_call && stk_full |=> stk_full && stk_wp == $past(stk_wp) + 3'h1;
  endproperty
  a_overflow: assert property (p_overflow)
    else $error("call on full stack did not wrap");

  property p_depth_bound;
    stk_depth <= isq_pkg::STK_DEPTH;
  endproperty
  a_depth_bound: assert property (p_depth_bound)
    else $error("stack depth above eight");

endmodule

// ### tb/isq_prog_mem.sv
// program memory model for the instruction sequencer bench
`timescale 1ns/100ps
module isq_prog_mem (
  // clock
  input logic sys_clk,
  // fetch port
  input logic fetch_req,
  input logic [12:0] fetch_addr,
  output logic [15:0] fetch_instr
);
  // each word carries its own address, so a wrong fetch shows at once
  function automatic logic [15:0] word(input logic [12:0] a);
    return {3'h5, a};
  endfunction

  initial fetch_instr = 16'h0000;

  // answer only in the cycle after the strobe; at other times the bus
  // toggles, so a sample taken one cycle late never sees a plausible word
  always @(posedge sys_clk) begin
    if (fetch_req) begin
      fetch_instr <= word(fetch_addr);
    end else begin
      fetch_instr <= ~fetch_instr;
    end
  end
endmodule

// ### tb/test_instruction_sequencer_pc_stack.sv
// self-checking bench for the instruction sequencer
`timescale 1ns/100ps
module test_instruction_sequencer_pc_stack;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [12:0] fetch_addr;
  logic fetch_req;
  logic [15:0] fetch_instr;
  logic [3:0] instruction_phase_clocks;
  logic [15:0] exec_instr;
  logic exec_valid;
  logic exec_second;
  logic ctl_unconditional_jump = 1'b0;
  logic ctl_call = 1'b0;
  logic ctl_subroutine_return = 1'b0;
  logic ctl_interrupt_return = 1'b0;
  logic ctl_skip = 1'b0;
  logic ctl_ext = 1'b0;
  logic [12:0] ctl_target = 13'h0000;
  logic alu_en = 1'b0;
  logic [3:0] alu_op = 4'h0;
  logic [7:0] alu_a = 8'h00;
  logic [7:0] alu_b = 8'h00;
  logic [7:0] alu_dest = 8'h00;
  logic [7:0] alu_result;
  logic alu_wr;
  logic [7:0] alu_wr_addr;
  logic status_carry;
  logic status_zero;
  logic int_req = 1'b0;
  logic [12:0] int_vector = 13'h0000;
  logic int_ack;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [12:0] cur;
  logic [12:0] stk[$];
  logic [7:0] rd_val;

  isq_sequencer isq_sequencer_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fetch_addr(fetch_addr),
    .fetch_req(fetch_req), .fetch_instr(fetch_instr),
    .instruction_phase_clocks(instruction_phase_clocks),
    .exec_instr(exec_instr), .exec_valid(exec_valid),
    .exec_second(exec_second),
    .ctl_unconditional_jump(ctl_unconditional_jump),
    .ctl_call(ctl_call), .ctl_subroutine_return(ctl_subroutine_return),
    .ctl_interrupt_return(ctl_interrupt_return), .ctl_skip(ctl_skip),
    .ctl_ext(ctl_ext), .ctl_target(ctl_target), .alu_en(alu_en),
    .alu_op(alu_op), .alu_a(alu_a), .alu_b(alu_b), .alu_dest(alu_dest),
    .alu_result(alu_result), .alu_wr(alu_wr), .alu_wr_addr(alu_wr_addr),
    .status_carry(status_carry), .status_zero(status_zero),
    .int_req(int_req), .int_vector(int_vector), .int_ack(int_ack)
  );

  isq_prog_mem isq_prog_mem_inst (
    .sys_clk(sys_clk), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_instr(fetch_instr)
  );

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // same word layout as the memory model
  function automatic logic [15:0] memw(input logic [12:0] a);
    return {3'h5, a};
  endfunction

  // reference stack: a full push drops the oldest entry
  task automatic push(input logic [12:0] a);
    if (stk.size() == 8) begin
      stk.delete(0);
    end
    stk.push_back(a);
  endtask

  // step to the given phase of a real instruction, just after the edge
  task automatic sync(input logic [3:0] ph);
    do begin
      @(posedge sys_clk);
      #1;
    end while (!(instruction_phase_clocks === ph && exec_valid === 1'b1));
  endtask

  // one flow decision in T4; c = {ext, skip, iret, ret, call, jump}
  task automatic issue(input logic [5:0] c, input logic [12:0] tgt,
                       input logic [12:0] nxt);
    sync(isq_pkg::ISQ_T3);
    @(posedge sys_clk);
    {ctl_ext, ctl_skip, ctl_interrupt_return, ctl_subroutine_return,
     ctl_call, ctl_unconditional_jump} <= c;
    ctl_target <= tgt;
    @(posedge sys_clk);
    {ctl_ext, ctl_skip, ctl_interrupt_return, ctl_subroutine_return,
     ctl_call, ctl_unconditional_jump} <= 6'h00;
    #1;
    check(fetch_addr, nxt);
    check(exec_second, c[5]);
    if (c[5]) begin
      check(fetch_req, 1'b0);
    end else begin
      check(exec_valid, 1'b0);
    end
    repeat (4) @(posedge sys_clk);
    #1;
    check(exec_valid, 1'b1);
    check(exec_instr, memw(nxt));
    check(fetch_addr, nxt + 13'h1);
    cur = nxt;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // alu request in T3; exp = {zero, carry, result}
  task automatic alu(input logic [3:0] op, input logic [7:0] a,
                     input logic [7:0] b, input logic [9:0] exp);
    sync(isq_pkg::ISQ_T2);
    @(posedge sys_clk);
    alu_en <= 1'b1;
    alu_op <= op;
    alu_a <= a;
    alu_b <= b;
    alu_dest <= a ^ b;
    @(posedge sys_clk);
    alu_en <= 1'b0;
    #1;
    check(alu_wr, 1'b1);
    check(alu_wr_addr, a ^ b);
    check({status_zero, status_carry, alu_result}, exp);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    #1;
    check(instruction_phase_clocks, 4'h1);
    check(fetch_addr, 13'h0000);
    check(exec_valid, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(posedge sys_clk);
      #1;
      check(instruction_phase_clocks, 4'h2 << k);
    end
    // plain stepping: fetch only in T1, one word ahead of execution
    for (int k = 0; k < 2; k++) begin
      sync(isq_pkg::ISQ_T1);
      check(exec_instr, memw(13'(k)));
      check(fetch_addr, 13'(k + 1));
      check(fetch_req, 1'b1);
      @(posedge sys_clk);
      #1;
      check(fetch_req, 1'b0);
    end
    cur = 13'h0001;
    issue(6'h01, 13'h0a40, 13'h0a40);
    issue(6'h10, 13'h0000, cur + 13'h2);
    issue(6'h20, 13'h0000, cur + 13'h1);
    // low byte write jumps inside the current page after a dummy cycle
    sync(isq_pkg::ISQ_T1);
    reg_write(isq_pkg::REG_PCL, 8'h12);
    repeat (2) @(posedge sys_clk);
    #1;
    check(fetch_addr, 13'h0a12);
    check(exec_valid, 1'b0);
    reg_read(isq_pkg::REG_PCL, rd_val);
    check(rd_val, 8'h12);
    sync(isq_pkg::ISQ_T1);
    check(exec_instr, memw(13'h0a12));
    cur = 13'h0a12;
    // fill all eight levels
    for (int i = 0; i < 8; i++) begin
      push(cur + 13'h1);
      issue(6'h02, 13'h1000 + 13'(i * 16), 13'h1000 + 13'(i * 16));
    end
    // full stack holds the acknowledge off for two instructions
    @(posedge sys_clk);
    int_req <= 1'b1;
    int_vector <= 13'h0004;
    repeat (8) begin
      @(posedge sys_clk);
      #1;
      check(int_ack, 1'b0);
    end
    cur = cur + 13'h2;
    issue(6'h04, 13'h0000, stk.pop_back());
    for (int n = 0; n < 8 && int_ack !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check(int_ack, 1'b1);
    check(fetch_addr, 13'h0004);
    push(cur + 13'h1);
    @(posedge sys_clk);
    int_req <= 1'b0;
    sync(isq_pkg::ISQ_T1);
    check(exec_instr, memw(13'h0004));
    cur = 13'h0004;
    // overflowing call, then unwind; the oldest return address is gone
    push(cur + 13'h1);
    issue(6'h02, 13'h1f00, 13'h1f00);
    for (int i = 0; i < 8; i++) begin
      issue(i == 0 ? 6'h08 : 6'h04, 13'h0000, stk.pop_back());
    end
    alu(isq_pkg::ISQ_ADD, 8'hf0, 8'h20, 10'h110);
    alu(isq_pkg::ISQ_SUB, 8'h05, 8'h05, 10'h300);
    alu(isq_pkg::ISQ_INC, 8'hff, 8'h00, 10'h300);
    alu(isq_pkg::ISQ_RR, 8'h01, 8'h00, 10'h180);
    reg_write(isq_pkg::REG_STATUS, 8'h02);
    reg_read(isq_pkg::REG_STATUS, rd_val);
    check(rd_val & 8'h03, 8'h01);
    reg_read(4'hf, rd_val);
    check(rd_val, 8'h00);
    conclude();
  end
endmodule
